// ===== include/npc_pkg.sv
// Package with register map, field layout and protection constants.
package npc_pkg;

  // ****************************************************************
  // Register offsets on the plain register port.
  // ****************************************************************
  localparam logic [3:0] NPC_OFS_CONFIG = 4'h0;
  localparam logic [3:0] NPC_OFS_PROT = 4'h1;
  localparam logic [3:0] NPC_OFS_STATUS = 4'h2;
  localparam logic [3:0] NPC_OFS_IRQ_MASK = 4'h3;
  localparam logic [3:0] NPC_OFS_SECURE = 4'h4;
  localparam logic [3:0] NPC_OFS_KEY_BASE = 4'h8;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int NPC_CFG_PAGE_BIT = 6;
  localparam int NPC_CFG_KEY_ACCESS_ENABLE_BIT = 5;
  localparam logic [7:0] NPC_CFG_MASK = 8'h60;
  localparam logic [7:0] NPC_CFG_RESET = 8'h00;
  localparam int NPC_PROT_OPEN_BIT = 0;
  localparam int NPC_STAT_VIOL_BIT = 5;
  localparam int NPC_STAT_MASSREF_BIT = 4;
  localparam logic [7:0] NPC_STAT_MASK = 8'h30;
  localparam logic [7:0] NPC_MASK_RESET = 8'h00;

  // ****************************************************************
  // Address windows of the arrays and the key window.
  // ****************************************************************
  localparam logic [15:0] NPC_KEY_WIN_LO = 16'hffb0;
  localparam logic [15:0] NPC_KEY_WIN_HI = 16'hffb7;
  localparam logic [1:0] NPC_DPS_NONE = 2'h3;
  localparam logic [13:0] NPC_DATA_TOP2 = 14'h3ff0;
  localparam logic [13:0] NPC_DATA_TOP1 = 14'h3fe0;
  localparam logic [13:0] NPC_DATA_TOP0 = 14'h3fc0;
  localparam logic [4:0] NPC_PPS_NONE = 5'h1f;
  localparam logic [4:0] NPC_PPS_ARR0_END = 5'h17;
  localparam logic [4:0] NPC_PPS_4K_END = 5'h10;
  localparam logic [16:0] NPC_ARR1_BASE = 17'h10000;
  localparam logic [16:0] NPC_ARR1_END = 17'h1ffff;

  // Commands presented to the protection check.
  typedef enum logic [1:0] {
    NPC_CMD_PROG,
    NPC_CMD_ERASE,
    NPC_CMD_MASS
  } npc_cmd_t;

endpackage

// ===== hw/npc_nvm_protect.sv
// Page select, key window and sector protection control for NVM arrays.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
module npc_nvm_protect
  import npc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic load_i,
  input wire logic [7:0] protection_image_i,
  input wire logic backdoor_enable_i,
  input wire logic [63:0] backdoor_key_store_i,
  input wire logic cpu_wr_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic cmd_start_o,
  input wire logic cmd_valid_i,
  input wire npc_cmd_t cmd_i,
  input wire logic cmd_data_arr_i,
  input wire logic [16:0] cmd_addr_i,
  output logic cmd_allow_o,
  output logic data_page_select_o,
  output logic unsecured_o,
  output logic irq_o
);

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************

  // Flags a data-array offset that lies inside the protected top range.
  function automatic logic data_hit(input logic [1:0] f,
                                    input logic [13:0] a);
    logic hit;
    hit = 1'b0;
    unique case (f)
      2'h2: hit = (a >= NPC_DATA_TOP2);
      2'h1: hit = (a >= NPC_DATA_TOP1);
      2'h0: hit = (a >= NPC_DATA_TOP0);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Size of the protected program range in 2 Kbyte units, 0 to 64.
  function automatic logic [6:0] prog_size(input logic [7:0] p);
    logic [6:0] sz;
    logic [4:0] f;
    sz = 7'h00;
    f = p[5:1];
    if (!p[NPC_PROT_OPEN_BIT]) begin
      sz = 7'h40;
    end else if (f == NPC_PPS_NONE) begin
      sz = 7'h00;
    end else if (f >= NPC_PPS_ARR0_END) begin
      sz = {5'(NPC_PPS_NONE - f), 2'b00};
    end else if (f >= NPC_PPS_4K_END) begin
      sz = 7'h20 + {1'b0, 5'(NPC_PPS_ARR0_END - f), 1'b0};
    end else begin
      sz = 7'h30 + {2'h0, 5'(NPC_PPS_4K_END - 5'h01 - f)};
    end
    return sz;
  endfunction

  // Flags a program-array offset that lies inside the protected range.
  function automatic logic prog_hit(input logic [7:0] p,
                                    input logic [16:0] a);
    logic [6:0] sz;
    logic low;
    logic hit;
    sz = prog_size(p);
    // Array 0 fills from its top first; the low size bits then count
    // down from the top of array 1, which stays free until then.
    low = ({1'b0, a[15:0]} >= (17'h10000 - {1'b0, sz[4:0], 11'h000}));
    if (!a[16]) begin
      hit = sz[6] || sz[5] || low;
    end else begin
      hit = sz[6] || (sz[5] && low);
    end
    return hit;
  endfunction

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] prot_ff, nxt_prot;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [63:0] key_ff, nxt_key;
  logic [7:0] key_seen_ff, nxt_key_seen;
  logic unsec_ff, nxt_unsec;
  logic start_ff, nxt_start;
  logic in_win;
  logic prot_hit;
  logic viol_evt;
  logic mass_evt;
  logic [2:0] key_idx;

  assign in_win = (cpu_addr_i >= NPC_KEY_WIN_LO) &&
                  (cpu_addr_i <= NPC_KEY_WIN_HI);
  assign key_idx = cpu_addr_i[2:0];

  // Protection check of the presented command against the live settings.
  always_comb begin
    prot_hit = 1'b0;
    if (cmd_data_arr_i) begin
      prot_hit = data_hit(prot_ff[7:6], cmd_addr_i[13:0]);
    end else begin
      prot_hit = prog_hit(prot_ff, cmd_addr_i);
    end
  end

  // Mass erase needs the whole targeted array free of protection.
  assign mass_evt = cmd_valid_i && (cmd_i == NPC_CMD_MASS) &&
    (cmd_data_arr_i ? (prot_ff[7:6] != NPC_DPS_NONE)
                    : (prog_size(prot_ff) != 7'h00));
  assign viol_evt = cmd_valid_i && (cmd_i != NPC_CMD_MASS) && prot_hit;
  assign cmd_allow_o = cmd_valid_i && !viol_evt && !mass_evt;

  // Next values for all software-visible state.
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_prot = prot_ff;
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_rdata = 8'h00;
    nxt_key = key_ff;
    nxt_key_seen = key_seen_ff;
    nxt_unsec = unsec_ff;
    nxt_start = 1'b0;
    if (load_i) begin
      nxt_prot = protection_image_i;
    end else if (reg_wr_i && reg_addr_i == NPC_OFS_PROT) begin
      if (prog_size(reg_wdata_i) >= prog_size(prot_ff) &&
          reg_wdata_i[7:6] <= prot_ff[7:6]) begin
        nxt_prot = reg_wdata_i;
      end
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        NPC_OFS_CONFIG: nxt_cfg = reg_wdata_i & NPC_CFG_MASK;
        NPC_OFS_STATUS: nxt_stat = stat_ff & ~reg_wdata_i;
        NPC_OFS_IRQ_MASK: nxt_mask = reg_wdata_i & NPC_STAT_MASK;
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (viol_evt) begin
      nxt_stat[NPC_STAT_VIOL_BIT] = 1'b1;
    end
    if (mass_evt) begin
      nxt_stat[NPC_STAT_MASSREF_BIT] = 1'b1;
    end
    // Window writes: key capture or command launch.
    if (cpu_wr_i && in_win) begin
      if (cfg_ff[NPC_CFG_KEY_ACCESS_ENABLE_BIT]) begin
        nxt_key[8*key_idx +: 8] = cpu_wdata_i;
        nxt_key_seen = (key_idx == 3'h0) ? 8'h01
                     : (key_seen_ff | (8'h01 << key_idx));
        if (key_idx == 3'h7 && backdoor_enable_i &&
            key_seen_ff == 8'h7f &&
            {cpu_wdata_i, key_ff[55:0]} == backdoor_key_store_i) begin
          nxt_unsec = 1'b1;
        end
      end else begin
        nxt_start = 1'b1;
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        NPC_OFS_CONFIG: nxt_rdata = cfg_ff;
        NPC_OFS_PROT: nxt_rdata = prot_ff;
        NPC_OFS_STATUS: nxt_rdata = stat_ff;
        NPC_OFS_IRQ_MASK: nxt_rdata = mask_ff;
        NPC_OFS_SECURE: nxt_rdata = {7'h00, unsec_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register the software-visible state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ff <= NPC_CFG_RESET;
      prot_ff <= 8'h00;
      stat_ff <= 8'h00;
      mask_ff <= NPC_MASK_RESET;
      rdata_ff <= 8'h00;
      key_ff <= 64'h0;
      key_seen_ff <= 8'h00;
      unsec_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      prot_ff <= nxt_prot;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      key_ff <= nxt_key;
      key_seen_ff <= nxt_key_seen;
      unsec_ff <= nxt_unsec;
      start_ff <= nxt_start;
    end
  end

  // Outputs.
  assign reg_rdata_o = rdata_ff;
  assign data_page_select_o = cfg_ff[NPC_CFG_PAGE_BIT];
  assign unsecured_o = unsec_ff;
  assign cmd_start_o = start_ff;
  assign irq_o = |(stat_ff & mask_ff);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_cfg_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (cfg_ff & ~NPC_CFG_MASK) == 8'h00)
    else $error("Undefined config bits set.");
  chk_page_map: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == NPC_OFS_CONFIG |=>
    data_page_select_o == $past(reg_wdata_i[NPC_CFG_PAGE_BIT]))
    else $error("Page select not applied.");
  chk_win_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cpu_wr_i && in_win && !cfg_ff[NPC_CFG_KEY_ACCESS_ENABLE_BIT] |=> cmd_start_o)
    else $error("Window write did not start command.");
  chk_key_nostart: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cpu_wr_i && cfg_ff[NPC_CFG_KEY_ACCESS_ENABLE_BIT] |=> !cmd_start_o)
    else $error("Key write started a command.");
  chk_image_load: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    load_i |=> prot_ff == $past(protection_image_i))
    else $error("Protection image not loaded.");
  // Outside a protection image load on load_i, both protected ranges may only grow.
  chk_prot_grow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !$past(load_i) && prot_ff != $past(prot_ff) |->
    prog_size(prot_ff) >= prog_size($past(prot_ff)) &&
    prot_ff[7:6] <= $past(prot_ff[7:6]))
    else $error("Protection region shrank.");
  chk_viol_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    viol_evt |-> !cmd_allow_o ##1 stat_ff[NPC_STAT_VIOL_BIT])
    else $error("Violation not flagged.");
  chk_mass_block: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_i && cmd_i == NPC_CMD_MASS && !cmd_data_arr_i &&
    !prot_ff[NPC_PROT_OPEN_BIT] |-> !cmd_allow_o)
    else $error("Mass erase allowed while protected.");
  chk_mass_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    mass_evt |-> !cmd_allow_o ##1 stat_ff[NPC_STAT_MASSREF_BIT])
    else $error("Refused mass erase not flagged.");
  chk_data_top: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_i && cmd_data_arr_i && cmd_i == NPC_CMD_PROG &&
    prot_ff[7:6] == 2'h0 && cmd_addr_i[13:0] >= NPC_DATA_TOP0 |->
    !cmd_allow_o)
    else $error("Data top not protected.");
  chk_data_free: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_i && cmd_data_arr_i && cmd_i != NPC_CMD_MASS &&
    prot_ff[7:6] == NPC_DPS_NONE |-> cmd_allow_o)
    else $error("Open data array refused.");
  chk_closed_all: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_i && !cmd_data_arr_i && !prot_ff[NPC_PROT_OPEN_BIT] |->
    !cmd_allow_o)
    else $error("Closed program array accepted a command.");
  chk_viol_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == NPC_OFS_STATUS &&
    reg_wdata_i[NPC_STAT_VIOL_BIT] && !viol_evt |=>
    !stat_ff[NPC_STAT_VIOL_BIT])
    else $error("Violation flag not cleared.");
  chk_open_none: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    prot_ff[0] && prot_ff[5:1] == NPC_PPS_NONE && cmd_valid_i &&
    !cmd_data_arr_i && cmd_i == NPC_CMD_PROG |-> cmd_allow_o)
    else $error("Open array refused.");
  // While array 0 alone is guarded, array 1 stays writable.
  chk_arr1_free: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_i && !cmd_data_arr_i && cmd_i != NPC_CMD_MASS &&
    prot_ff[NPC_PROT_OPEN_BIT] && prot_ff[5:1] >= NPC_PPS_ARR0_END &&
    cmd_addr_i[16] |-> cmd_allow_o)
    else $error("Upper program array refused.");
  chk_unsec_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    unsec_ff |=> unsec_ff)
    else $error("Security re-engaged before reset.");

endmodule

// ===== verif/npc_nvm_protect_tb.sv
// Self-checking testbench for the NVM page and protection control block.
`timescale 1ns/100ps
module npc_nvm_protect_tb
  import npc_pkg::*;
();
  logic clk, rst_n, wr, rd, load, bk_en, cpu_wr, cmd_valid, cmd_data;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, image, cpu_wdata;
  logic [63:0] key;
  logic [15:0] cpu_addr;
  logic [16:0] cmd_addr;
  npc_cmd_t cmd;
  logic cmd_start, allow, page, unsec, irq;
  int fails, num_checks;
  logic [7:0] img [6] = '{8'hef, 8'hf1, 8'hed, 8'he1, 8'hdd, 8'hc1};
  logic [16:0] lo [6] = '{17'h00000, 17'h02000, 17'h1f000, 17'h19000,
                          17'h17800, 17'h10800};

  npc_nvm_protect u_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .load_i(load), .protection_image_i(image), .backdoor_enable_i(bk_en),
    .backdoor_key_store_i(key), .cpu_wr_i(cpu_wr), .cpu_addr_i(cpu_addr),
    .cpu_wdata_i(cpu_wdata), .cmd_start_o(cmd_start),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_data_arr_i(cmd_data),
    .cmd_addr_i(cmd_addr), .cmd_allow_o(allow),
    .data_page_select_o(page), .unsecured_o(unsec), .irq_o(irq));

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  task end_of_test;
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // The allow answer is combinational, so it is judged within the cycle.
  task cmd_chk(input npc_cmd_t c, input logic d, input logic [16:0] a,
               input logic exp);
    @(posedge clk);
    cmd <= c; cmd_data <= d; cmd_addr <= a; cmd_valid <= 1'b1;
    #1 check(allow, exp);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task cpu_write(input logic [15:0] a, input logic [7:0] d, input logic exp);
    @(posedge clk);
    cpu_wr <= 1'b1; cpu_addr <= a; cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
    #1 check(cmd_start, exp);
  endtask

  task load_prot(input logic [7:0] v);
    @(posedge clk);
    image <= v; load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task t_reset;
    rd_chk(NPC_OFS_CONFIG, NPC_CFG_RESET);
    rd_chk(NPC_OFS_IRQ_MASK, NPC_MASK_RESET);
    rd_chk(4'h7, 8'h00);
    load_prot(8'hff);
    rd_chk(NPC_OFS_PROT, 8'hff);
  endtask

  task t_config;
    reg_wr(NPC_OFS_CONFIG, 8'hff);
    rd_chk(NPC_OFS_CONFIG, NPC_CFG_MASK);
    check(page, 1'b1);
    reg_wr(NPC_OFS_CONFIG, 8'h00);
    check(page, 1'b0);
  endtask

  task t_prot;
    reg_wr(NPC_OFS_PROT, 8'h3d);
    rd_chk(NPC_OFS_PROT, 8'h3d);
    reg_wr(NPC_OFS_PROT, 8'hff);
    reg_wr(NPC_OFS_PROT, 8'h7d);
    rd_chk(NPC_OFS_PROT, 8'h3d);
    cmd_chk(NPC_CMD_PROG, 1'b0, 17'h0e000, 1'b0);
    cmd_chk(NPC_CMD_ERASE, 1'b0, 17'h0dfff, 1'b1);
    cmd_chk(NPC_CMD_PROG, 1'b1, 17'h03fc0, 1'b0);
    cmd_chk(NPC_CMD_ERASE, 1'b1, 17'h03fbf, 1'b1);
    cmd_chk(NPC_CMD_MASS, 1'b0, 17'h00000, 1'b0);
    rd_chk(NPC_OFS_STATUS, NPC_STAT_MASK);
    check(irq, 1'b0);
    reg_wr(NPC_OFS_IRQ_MASK, 8'h20);
    check(irq, 1'b1);
    reg_wr(NPC_OFS_STATUS, 8'h20);
    check(irq, 1'b0);
    rd_chk(NPC_OFS_STATUS, 8'h10);
  endtask

  task t_ranges;
    load_prot(8'hfe);
    cmd_chk(NPC_CMD_PROG, 1'b0, 17'h1ffff, 1'b0);
    cmd_chk(NPC_CMD_ERASE, 1'b0, 17'h00000, 1'b0);
    load_prot(8'hff);
    cmd_chk(NPC_CMD_PROG, 1'b0, 17'h1ffff, 1'b1);
    cmd_chk(NPC_CMD_MASS, 1'b0, 17'h00000, 1'b1);
    cmd_chk(NPC_CMD_MASS, 1'b1, 17'h00000, 1'b1);
    cmd_chk(NPC_CMD_PROG, 1'b1, 17'h03fff, 1'b1);
    load_prot(8'hbf);
    cmd_chk(NPC_CMD_PROG, 1'b1, 17'h03ff0, 1'b0);
    cmd_chk(NPC_CMD_ERASE, 1'b1, 17'h03fef, 1'b1);
    cmd_chk(NPC_CMD_PROG, 1'b0, 17'h1ffff, 1'b1);
    for (int i = 0; i < 6; i++) begin
      load_prot(img[i]);
      cmd_chk(NPC_CMD_PROG, 1'b0, lo[i], 1'b0);
      cmd_chk(NPC_CMD_ERASE, 1'b0, lo[i] - 17'h1, 1'b1);
    end
  endtask

  task t_key;
    cpu_write(16'hffb3, 8'h55, 1'b1);
    cpu_write(16'hffb8, 8'h55, 1'b0);
    cpu_write(16'hffaf, 8'h55, 1'b0);
    reg_wr(NPC_OFS_CONFIG, 8'h20);
    for (int k = 0; k < 8; k++)
      cpu_write(NPC_KEY_WIN_LO + 16'(k), key[8*k+:8] ^ 8'(k == 7), 1'b0);
    check(unsec, 1'b0);
    for (int k = 0; k < 8; k++)
      cpu_write(NPC_KEY_WIN_LO + 16'(k), key[8*k+:8], 1'b0);
    check(unsec, 1'b1);
    rd_chk(NPC_OFS_SECURE, 8'h01);
  endtask

  // Free-running bus clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end

  // Main sequence.
  initial begin
    {rst_n, wr, rd, load, cpu_wr, cmd_valid, cmd_data} = '0;
    bk_en = 1'b1;
    addr = '0; wdata = '0; image = '0; cpu_wdata = '0; cpu_addr = '0;
    cmd_addr = '0; cmd = NPC_CMD_PROG;
    key = 64'h0123456789abcdef;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_config;
    t_prot;
    t_ranges;
    t_key;
    end_of_test;
  end
endmodule
